// ===== hw/prox_engine_config_regs.v
// Configuration and control slice of a proximity measurement engine, with its register port.
// Assumes all inputs synchronous to core_clk; samples arrive already hardware-averaged.
`timescale 1ns/10ps
`include "prox_engine_defines.vh"

module prox_engine_config_regs #(
    parameter STEP_CYCLES = `WAIT_STEP_CYCLES,
    parameter DATA_W      = 14,
    parameter AVG_MAX     = 8
) (
    input  wire              core_clk,
    input  wire              arst_n,
    input  wire [7:0]        reg_addr,
    input  wire [7:0]        reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [7:0]        reg_rdata,
    input  wire              power_on_control,
    input  wire              long_wait_enable,
    input  wire              prox_interrupt_enable,
    input  wire [3:0]        persistence,
    input  wire [DATA_W-1:0] thresh_low,
    input  wire [DATA_W-1:0] thresh_high,
    input  wire [7:0]        flag_events,
    input  wire [DATA_W-1:0] hw_avg_sample,
    input  wire              hw_avg_valid,
    output reg               meas_start,
    output reg  [DATA_W-1:0] prox_result,
    output wire              auto_pulse_control,
    output wire              far_diode_en,
    output wire              near_diode_en,
    output wire              osc_running,
    output wire              int_pin_out,
    output wire              int_pin_oe_n
);

    localparam ST_IDLE    = 2'd0;
    localparam ST_MEASURE = 2'd1;
    localparam ST_WAIT    = 2'd2;
    localparam ST_SLEEP   = 2'd3;
    localparam SUM_W      = DATA_W + 3;

    reg [7:0]        wait_steps_reg;
    reg [7:0]        pd_select_reg;
    reg [7:0]        int_behav_reg;
    reg [7:0]        pulse_ctrl_reg;
    reg [7:0]        filter_reg;
    reg [7:0]        status_reg;
    reg [1:0]        state_reg;
    reg [8:0]        step_count_reg;
    reg [31:0]       tick_count_reg;
    reg [3:0]        mult_count_reg;
    reg [3:0]        persist_count_reg;
    reg [DATA_W-1:0] hist_reg [0:AVG_MAX-1];

    wire       soft_reset = reg_wr && (reg_addr == `SOFT_RESET_OFFSET)
                            && reg_wdata[`SOFT_RESET_BIT];
    wire       status_rd  = reg_rd && (reg_addr == `STATUS_OFFSET);
    wire       status_wr  = reg_wr && (reg_addr == `STATUS_OFFSET);
    wire       pulse_off  = pulse_ctrl_reg[`PULSE_OFF_BIT];
    wire       sleep_after_interrupt = int_behav_reg[`SLEEP_INT_BIT];
    wire       int_active = status_reg[`STATUS_PROX_INT_BIT] && prox_interrupt_enable;
    wire [1:0] avg_depth  = filter_reg[1:0];

    assign auto_pulse_control = !pulse_off;
    assign far_diode_en       = pd_select_reg[0];
    assign near_diode_en      = pd_select_reg[1];
    // Halt gates osc_running (and stops new measurements) even though power_on_control stays high
    assign osc_running        = power_on_control && (state_reg != ST_SLEEP);
    assign int_pin_out        = 1'b0;
    assign int_pin_oe_n       = !int_active;

    // Moving average over the newest 2^depth samples
    reg [SUM_W-1:0]  avg_sum;
    reg [DATA_W-1:0] avg_value;
    reg [DATA_W-1:0] filt_value;
    integer i;
    always @* begin
        avg_sum = {SUM_W{1'b0}};
        for (i = 0; i < AVG_MAX; i = i + 1) begin
            if (i == 0 || (avg_depth != 2'b00 && i < (1 << avg_depth))) begin
                avg_sum = avg_sum + {3'b000, (i == 0) ? hw_avg_sample : hist_reg[i-1]};
            end
        end
        avg_value = avg_sum[avg_depth +: DATA_W];
        // Pulse control off keeps only a 10-bit result
        filt_value = pulse_off ? {4'h0, avg_value[9:0]} : avg_value;
    end

    // Threshold test on the filtered value
    wire over  = pulse_off ? (filt_value[9:2] > thresh_high[7:0]) : (filt_value > thresh_high);
    wire under = pulse_off ? (filt_value[9:2] < thresh_low[7:0])  : (filt_value < thresh_low);
    wire done  = (state_reg == ST_MEASURE) && hw_avg_valid;
    wire hit   = done && (over || under) && ({1'b0, persist_count_reg} + 5'd1 >= {1'b0, persistence});
    wire fire  = hit;

    // Status flags: hardware set wins over a write-clear or read-clear in the same cycle
    reg [7:0] status_next;
    reg [7:0] status_set;
    always @* begin
        status_set = flag_events & 8'h2f;
        if (fire) begin
            status_set[`STATUS_PROX_INT_BIT] = 1'b1;
            status_set[`STATUS_HIGH_BIT] = over;
            status_set[`STATUS_LOW_BIT]  = under;
        end
        status_next = status_reg;
        if (status_wr) begin
            status_next = status_next & ~reg_wdata;
        end
        if (status_rd && int_behav_reg[`READ_CLEAR_BIT]) begin
            status_next = 8'h00;
        end
        status_next = status_next | status_set;
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_steps_reg <= `WAIT_RESET;
            pd_select_reg  <= `PD_SELECT_RESET;
            int_behav_reg  <= `INT_BEHAV_RESET;
            pulse_ctrl_reg <= `PULSE_CTRL_RESET;
            filter_reg     <= `FILTER_RESET;
            status_reg     <= 8'h00;
            reg_rdata      <= 8'h00;
        end else if (soft_reset) begin
            wait_steps_reg <= `WAIT_RESET;
            pd_select_reg  <= `PD_SELECT_RESET;
            int_behav_reg  <= `INT_BEHAV_RESET;
            pulse_ctrl_reg <= `PULSE_CTRL_RESET;
            filter_reg     <= `FILTER_RESET;
            status_reg     <= 8'h00;
            reg_rdata      <= 8'h00;
        end else begin
            status_reg <= status_next;
            if (reg_wr) begin
                case (reg_addr)
                    `WAIT_OFFSET:       wait_steps_reg <= reg_wdata;
                    `PD_SELECT_OFFSET:  pd_select_reg  <= reg_wdata;
                    `INT_BEHAV_OFFSET:  int_behav_reg  <= reg_wdata;
                    `PULSE_CTRL_OFFSET: pulse_ctrl_reg <= reg_wdata;
                    `FILTER_OFFSET:     filter_reg     <= reg_wdata;
                    default: ;
                endcase
            end
            if (reg_rd) begin
                case (reg_addr)
                    `STATUS_OFFSET:     reg_rdata <= status_reg;
                    `WAIT_OFFSET:       reg_rdata <= wait_steps_reg;
                    `PD_SELECT_OFFSET:  reg_rdata <= pd_select_reg;
                    `INT_BEHAV_OFFSET:  reg_rdata <= int_behav_reg;
                    `PULSE_CTRL_OFFSET: reg_rdata <= pulse_ctrl_reg;
                    `FILTER_OFFSET:     reg_rdata <= filter_reg;
                    default:            reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Sample history shifts once per completed measurement
    genvar g;
    generate
        for (g = 0; g < AVG_MAX; g = g + 1) begin : hist
            always @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    hist_reg[g] <= {DATA_W{1'b0}};
                end else if (soft_reset) begin
                    hist_reg[g] <= {DATA_W{1'b0}};
                end else if (done) begin
                    hist_reg[g] <= (g == 0) ? hw_avg_sample : hist_reg[(g == 0) ? 0 : g-1];
                end
            end
        end
    endgenerate

    // Measurement cycle sequencer
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg         <= ST_IDLE;
            step_count_reg    <= 9'h000;
            tick_count_reg    <= 32'h0;
            mult_count_reg    <= 4'h0;
            persist_count_reg <= 4'h0;
            prox_result       <= {DATA_W{1'b0}};
            meas_start        <= 1'b0;
        end else if (soft_reset || !power_on_control) begin
            state_reg         <= ST_IDLE;
            persist_count_reg <= 4'h0;
            meas_start        <= 1'b0;
            if (soft_reset) begin
                prox_result <= {DATA_W{1'b0}};
            end
        end else begin
            meas_start <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    meas_start <= 1'b1;
                    state_reg  <= ST_MEASURE;
                end
                ST_MEASURE: begin
                    if (hw_avg_valid) begin
                        prox_result <= filt_value;
                        if (over || under) begin
                            if (persist_count_reg != 4'hf) begin
                                persist_count_reg <= persist_count_reg + 4'h1;
                            end
                        end else begin
                            persist_count_reg <= 4'h0;
                        end
                        // Sleep decision taken only here, at cycle end
                        if (sleep_after_interrupt && prox_interrupt_enable
                            && status_next[`STATUS_PROX_INT_BIT]) begin
                            state_reg <= ST_SLEEP;
                        end else begin
                            state_reg      <= ST_WAIT;
                            step_count_reg <= {1'b0, wait_steps_reg} + 9'h001;
                            tick_count_reg <= STEP_CYCLES - 1;
                            mult_count_reg <= long_wait_enable ? 4'd11 : 4'd0;
                        end
                    end
                end
                ST_WAIT: begin
                    if (tick_count_reg != 32'h0) begin
                        tick_count_reg <= tick_count_reg - 32'h1;
                    end else if (mult_count_reg != 4'h0) begin
                        mult_count_reg <= mult_count_reg - 4'h1;
                        tick_count_reg <= STEP_CYCLES - 1;
                    end else if (step_count_reg != 9'h001) begin
                        step_count_reg <= step_count_reg - 9'h001;
                        tick_count_reg <= STEP_CYCLES - 1;
                        mult_count_reg <= long_wait_enable ? 4'd11 : 4'd0;
                    end else begin
                        meas_start <= 1'b1;
                        state_reg  <= ST_MEASURE;
                    end
                end
                ST_SLEEP: begin
                    // Clearing the flags wakes it; power_on_control going low also returns it to ST_IDLE
                    if (status_reg == 8'h00) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

endmodule

// ===== hw/prox_engine_defines.vh
// Register offsets, field positions, reset values and timing for the proximity engine slice.
// Assumes a byte-wide register port with one address per register.
`ifndef PROX_ENGINE_DEFINES_VH
`define PROX_ENGINE_DEFINES_VH

`define STATUS_OFFSET       8'h9b
`define SOFT_RESET_OFFSET   8'ha8
`define WAIT_OFFSET         8'ha9
`define PD_SELECT_OFFSET    8'haa
`define INT_BEHAV_OFFSET    8'hab
`define PULSE_CTRL_OFFSET   8'hae
`define FILTER_OFFSET       8'hb3

`define WAIT_RESET          8'h00
`define PD_SELECT_RESET     8'h02
`define INT_BEHAV_RESET     8'h04
`define PULSE_CTRL_RESET    8'h3f
`define FILTER_RESET        8'h00

`define READ_CLEAR_BIT      7
`define SLEEP_INT_BIT       4
`define PULSE_OFF_BIT       6
`define SOFT_RESET_BIT      0
`define STATUS_HIGH_BIT     7
`define STATUS_LOW_BIT      6
`define STATUS_PROX_INT_BIT 4

`define CLK_FREQ_HZ         10000000
`define WAIT_STEP_NS        2780000
`define WAIT_STEP_CYCLES    ((`WAIT_STEP_NS / 1000) * (`CLK_FREQ_HZ / 1000000))
`define LONG_WAIT_FACTOR    12

`endif

// ===== tb/hw_avg_model.sv
// Hardware averaging stage answering each measurement request after a fixed latency.
// Assumes the bench sets next_sample before the request is answered.
`timescale 1ns/10ps
module hw_avg_model #(
    parameter LAT = 3
) (
    input  wire        core_clk,
    input  wire        meas_start,
    input  wire [13:0] next_sample,
    output reg  [13:0] hw_avg_sample,
    output reg         hw_avg_valid
);
    integer cnt = 0;
    initial begin
        hw_avg_sample = 14'h0000;
        hw_avg_valid = 1'b0;
    end
    always @(posedge core_clk) begin
        hw_avg_valid <= 1'b0;
        hw_avg_sample <= ~hw_avg_sample;  // Never hold the old sample outside valid
        if (meas_start) cnt <= LAT;
        else if (cnt > 1) cnt <= cnt - 1;
        else if (cnt == 1) begin
            cnt <= 0;
            hw_avg_valid <= 1'b1;
            hw_avg_sample <= next_sample;
        end
    end
endmodule

// ===== tb/prox_engine_chk.sv
// Port-level checks for the proximity engine slice.
// Assumes STEP_CYCLES of 4 and an averaging stage answering 3 cycles after a request.
`timescale 1ns/10ps
module prox_engine_chk #(
    parameter DATA_W = 14
) (
    input wire              core_clk,
    input wire              arst_n,
    input wire [7:0]        reg_addr,
    input wire [7:0]        reg_wdata,
    input wire              reg_wr,
    input wire              power_on_control,
    input wire              hw_avg_valid,
    input wire              meas_start,
    input wire [DATA_W-1:0] prox_result,
    input wire              auto_pulse_control,
    input wire              far_diode_en,
    input wire              near_diode_en,
    input wire              osc_running,
    input wire              int_pin_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_halt_needs_int: assert property ($fell(osc_running) && power_on_control &&
        $past(power_on_control) |-> !int_pin_oe_n) else $error("halt without interrupt");
    a_halt_cycle_end: assert property ($fell(osc_running) && power_on_control |->
        $past(hw_avg_valid) || $past(hw_avg_valid, 2) || $past(hw_avg_valid, 3))
        else $error("halt away from cycle end");
    a_restart_cleared: assert property ($rose(osc_running) && $past(power_on_control)
        |-> int_pin_oe_n) else $error("restart with interrupt pending");
    a_halted_quiet: assert property (!osc_running |-> !meas_start)
        else $error("request while halted");
    a_wait_gap: assert property (meas_start |=> !meas_start [*6])
        else $error("requests too close");
    a_result_cause: assert property ($changed(prox_result) |->
        $past(hw_avg_valid) || $past(reg_wr)) else $error("result changed without sample");
    a_ten_bit: assert property ($changed(prox_result) && !auto_pulse_control &&
        $past(!auto_pulse_control) |-> prox_result[DATA_W-1:10] == 0)
        else $error("wide result with pulse control off");
    a_diode_route: assert property (reg_wr && reg_addr == 8'haa |=>
        {near_diode_en, far_diode_en} == $past(reg_wdata[1:0])) else $error("diode routing");
    a_pulse_ctrl: assert property (reg_wr && reg_addr == 8'hae |=>
        auto_pulse_control == !$past(reg_wdata[6])) else $error("pulse control bit");
endmodule
bind prox_engine_config_regs prox_engine_chk #(.DATA_W(DATA_W)) i_chk (.core_clk(core_clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .power_on_control(power_on_control), .hw_avg_valid(hw_avg_valid),
    .meas_start(meas_start), .prox_result(prox_result), .auto_pulse_control(auto_pulse_control),
    .far_diode_en(far_diode_en), .near_diode_en(near_diode_en), .osc_running(osc_running),
    .int_pin_oe_n(int_pin_oe_n));

// ===== tb/test_prox_engine_config_regs.sv
// Self-checking bench for the proximity engine slice with an averaging-stage model.
// Assumes STEP_CYCLES shortened to 4 and an averaging stage answering after 3 cycles.
`timescale 1ns/10ps
`include "prox_engine_defines.vh"
module test_prox_engine_config_regs;
    localparam STEP = 4;
    reg         core_clk, arst_n, reg_wr, reg_rd, power_on_control, long_w, int_en;
    reg  [3:0]  persist;
    reg  [7:0]  reg_addr, reg_wdata, flag_events;
    reg  [13:0] th_high, th_low, nxt;
    reg  [13:0] hist [0:7];
    reg  [31:0] seed;
    wire [7:0]  reg_rdata;
    wire [13:0] smp, prox_result;
    wire        valid, meas_start, auto_pulse_control, far_en, near_en, osc, int_out, int_oe_n;
    integer     n_mismatch, compares, i, j, d, g1, g2, g3;
    prox_engine_config_regs #(.STEP_CYCLES(STEP)) i_dut (.core_clk(core_clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .power_on_control(power_on_control), .long_wait_enable(long_w),
        .prox_interrupt_enable(int_en), .persistence(persist), .thresh_low(th_low),
        .thresh_high(th_high), .flag_events(flag_events), .hw_avg_sample(smp),
        .hw_avg_valid(valid), .meas_start(meas_start), .prox_result(prox_result),
        .auto_pulse_control(auto_pulse_control), .far_diode_en(far_en),
        .near_diode_en(near_en), .osc_running(osc), .int_pin_out(int_out),
        .int_pin_oe_n(int_oe_n));
    hw_avg_model i_avg (.core_clk(core_clk), .meas_start(meas_start), .next_sample(nxt),
        .hw_avg_sample(smp), .hw_avg_valid(valid));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function [13:0] avg_of(input integer dep);
        reg [16:0] s;
        integer k;
        begin
            s = 0;
            for (k = 0; k < (1 << dep); k = k + 1) s = s + hist[k];
            avg_of = s >> dep;
        end
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(posedge core_clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= v;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rdc(input [7:0] a, input [7:0] exp);
        begin
            @(posedge core_clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1 check(reg_rdata, exp);
        end
    endtask
    task hard_reset;
        begin
            power_on_control <= 1'b0;
            arst_n <= 1'b0;
            repeat (5) @(posedge core_clk);
            arst_n <= 1'b1;
        end
    endtask
    task gap(output integer n);
        begin
            n = 0;
            @(posedge meas_start);
            while (n == 0 || !meas_start) begin
                @(posedge core_clk);
                #1 n = n + 1;
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("compares %0d n_mismatch %0d", compares, n_mismatch);
            if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        #5000000;  // About eight times the expected run
        n_mismatch = n_mismatch + 1;
        report_and_stop;
    end
    initial begin
        {arst_n, reg_wr, reg_rd, power_on_control, long_w, int_en} = 6'h00;
        {reg_addr, reg_wdata, flag_events, nxt} = 38'h0;
        th_high = 14'h3fff;
        th_low = 14'h0000;
        persist = 4'h1;
        seed = 32'd13;
        n_mismatch = 0;
        compares = 0;
        hard_reset;
        rdc(`WAIT_OFFSET, `WAIT_RESET);
        rdc(`PD_SELECT_OFFSET, `PD_SELECT_RESET);
        rdc(`INT_BEHAV_OFFSET, `INT_BEHAV_RESET);
        rdc(`PULSE_CTRL_OFFSET, `PULSE_CTRL_RESET);
        rdc(`FILTER_OFFSET, `FILTER_RESET);
        rdc(8'hb0, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            seed = xs(seed);
            wr(`PD_SELECT_OFFSET, i);
            wr(`PULSE_CTRL_OFFSET, {1'b0, seed[0], 6'h3f});
            #1 check({near_en, far_en, auto_pulse_control}, {i[1:0], ~seed[0]});
            rdc(`PD_SELECT_OFFSET, i);
        end
        for (d = 0; d < 4; d = d + 1) begin
            hard_reset;
            for (i = 0; i < 8; i = i + 1) hist[i] = 14'h0000;
            wr(`FILTER_OFFSET, d);
            if (d == 3) wr(`PULSE_CTRL_OFFSET, 8'h7f);  // Pulse control off on the last pass
            power_on_control <= 1'b1;
            for (i = 0; i < 10; i = i + 1) begin
                seed = xs(seed);
                nxt <= (i == 3) ? 14'h3fff : seed[13:0];
                @(posedge valid);
                #1 for (j = 7; j > 0; j = j - 1) hist[j] = hist[j-1];
                hist[0] = smp;
                @(posedge core_clk);
                #1 if (d < 3) check(prox_result, avg_of(d));
                else check(prox_result, avg_of(d) & 14'h03ff);
            end
        end
        hard_reset;
        wr(`WAIT_OFFSET, 8'h02);
        power_on_control <= 1'b1;
        gap(g1);
        gap(g1);
        wr(`WAIT_OFFSET, 8'h05);
        gap(g2);
        gap(g2);
        check(g2 - g1, 3 * STEP);
        long_w <= 1'b1;
        gap(g3);
        gap(g3);
        check(g3 - g2, 6 * STEP * 11);
        long_w <= 1'b0;
        wr(`WAIT_OFFSET, 8'hff);
        gap(g3);
        gap(g3);
        check(g3 - g2, 250 * STEP);
        hard_reset;
        th_high <= 14'h0000;
        int_en <= 1'b1;
        nxt <= 14'h0100;
        wr(`INT_BEHAV_OFFSET, 8'h14);
        power_on_control <= 1'b1;
        repeat (40) @(posedge core_clk);
        #1 check({osc, int_oe_n, int_out}, 3'b000);
        rdc(`STATUS_OFFSET, 8'h90);
        check(osc, 1'b0);
        wr(`STATUS_OFFSET, 8'hff);
        @(posedge core_clk);
        #1 check({osc, int_oe_n}, 2'b11);
        wr(`INT_BEHAV_OFFSET, 8'h94);
        repeat (40) @(posedge core_clk);
        rdc(`STATUS_OFFSET, 8'h90);
        @(posedge core_clk);
        #1 check(osc, 1'b1);
        hard_reset;
        // Low threshold crossed every sample; flag only on the third one
        persist <= 4'h3;
        th_high <= 14'h3fff;
        th_low <= 14'h0200;
        power_on_control <= 1'b1;
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge valid);
            @(posedge core_clk);
            #1 check(int_oe_n, i < 2);
        end
        rdc(`STATUS_OFFSET, 8'h50);
        hard_reset;
        @(posedge core_clk);
        flag_events <= 8'h2f;
        @(posedge core_clk);
        flag_events <= 8'h00;
        rdc(`STATUS_OFFSET, 8'h2f);
        wr(`STATUS_OFFSET, 8'h0f);
        rdc(`STATUS_OFFSET, 8'h20);
        report_and_stop;
    end
endmodule
